// ===== rtl/tbid_map.svh
`ifndef TBID_MAP_SVH
`define TBID_MAP_SVH
`define TBID_W          12
`define TBID_OP_HI      11
`define TBID_OP_LO      9
`define TBID_EXT_HI     8
`define TBID_EXT_LO     0
`define TBID_SEL_HI     8
`define TBID_SEL_LO     3
`define TBID_P4_BIT     2
`define TBID_P2_BIT     1
`define TBID_P1_BIT     0
`define TBID_MSB        11
`define TBID_ONE        12'h001
`define TBID_TWO        12'h002
`define TBID_ZERO       12'h000
`define TBID_CLK_NS     100
`define TBID_CYC_NS     1500
`define TBID_MRI_NS     3000
`define TBID_AUG_CYC    ((`TBID_CYC_NS + `TBID_CLK_NS - 1) / `TBID_CLK_NS)
`define TBID_MRI_CYC    ((`TBID_MRI_NS + `TBID_CLK_NS - 1) / `TBID_CLK_NS)
`define TBID_CNT_W      6
`endif

// ===== rtl/tbid_pkg.sv
`default_nettype none
package tbid_pkg;
  typedef enum logic [2:0] {
    TBID_OP_AND, TBID_OP_ADD, TBID_OP_ISZ_, TBID_OP_DEP, TBID_OP_CALL, TBID_OP_JUMP,
    TBID_OP_IO, TBID_OP_OPR
  } tbid_op_t;
  typedef enum logic [1:0] {TBID_IDLE, TBID_EXEC, TBID_DONE} tbid_state_t;
endpackage
`default_nettype wire

// ===== rtl/tbid_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "tbid_map.svh"
// Summary of operation
// RULE1 - Opcode is the top three bits
// RULE2 - Codes zero to five reference memory
// RULE3 - Code six I/O, seven operate
// RULE4 - Low nine bits extend augmented opcodes
// RULE5 - Augmented instructions take one 1.5us cycle
// RULE6 - I/O select is instruction bits 3-8
// RULE7 - Bits 9,10,11 enable pulses 4,2,1
// RULE8 - AND operand into working register
// RULE9 - Add operand, carry inverts link
// RULE10 - Increment operand, skip if zero
// RULE11 - Deposit working register then clear it
// RULE12 - Store PC at Y, continue Y+1
// RULE13 - Jump loads target into PC
// RULE14 - PC increments per fetch, skip adds one
// RULE15 - Target address comes from outside stage
module tbid_decode
  import tbid_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // Instruction issue
  input  wire logic              start,
  input  wire logic [11:0]       instr,
  input  wire logic [11:0]       target_addr,
  input  wire logic [11:0]       mem_rdata,
  // Results
  output logic                   busy_ff,
  output logic                   done_ff,
  output logic [11:0]            working_register_ff,
  output logic                   link_ff,
  output logic [11:0]            pc_ff,
  output logic                   mem_we_ff,
  output logic [11:0]            mem_addr_ff,
  output logic [11:0]            mem_wdata_ff,
  // Decode outputs
  output logic [2:0]             opcode_ff,
  output logic                   mem_ref_ff,
  output logic                   io_transfer_class_ff,
  output logic                   operate_class_ff,
  output logic [8:0]             op_ext_ff,
  output logic [5:0]             dev_sel_ff,
  output logic                   pulse4_en_ff,
  output logic                   pulse2_en_ff,
  output logic                   pulse1_en_ff
);
  tbid_state_t            state_ff;
  logic [`TBID_CNT_W-1:0] cnt_ff;

  // Instruction field decode
  wire [2:0]  op_w     = instr[`TBID_OP_HI:`TBID_OP_LO]; // RULE1
  wire        is_mem   = (op_w <= 3'(TBID_OP_JUMP)); // RULE2
  wire        is_io    = (op_w == 3'(TBID_OP_IO)); // RULE3
  wire        is_opr   = (op_w == 3'(TBID_OP_OPR)); // RULE3
  wire [8:0]  ext_w    = instr[`TBID_EXT_HI:`TBID_EXT_LO]; // RULE4
  wire [5:0]  sel_w    = instr[`TBID_SEL_HI:`TBID_SEL_LO]; // RULE6
  // Operation datapath
  wire [12:0] sum_w    = {1'b0, working_register_ff} + {1'b0, mem_rdata}; // RULE9
  wire [11:0] inc_w    = mem_rdata + `TBID_ONE; // RULE10
  wire        inc_zero = (inc_w == `TBID_ZERO); // RULE10
  wire [11:0] pc_next  = pc_ff + `TBID_ONE; // RULE14
  wire [11:0] pc_skip  = pc_ff + `TBID_TWO; // RULE14
  wire [11:0] ret_w    = pc_ff; // RULE12
  wire [11:0] call_pc  = target_addr + `TBID_ONE; // RULE12
  // Jump takes one cycle; the rest of memory references need two
  wire [`TBID_CNT_W-1:0] len_w =
    (is_io || is_opr || op_w == 3'(TBID_OP_JUMP)) ? `TBID_CNT_W'(`TBID_AUG_CYC) // RULE5 RULE13
                                                    : `TBID_CNT_W'(`TBID_MRI_CYC);
  wire        go_w     = clk_en && (state_ff == TBID_IDLE) && start;
  wire        last_w   = (cnt_ff == `TBID_CNT_W'(1));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff             <= TBID_IDLE;
      cnt_ff               <= '0;
      busy_ff              <= 1'b0;
      done_ff              <= 1'b0;
      opcode_ff            <= 3'h0;
      mem_ref_ff           <= 1'b0;
      io_transfer_class_ff <= 1'b0;
      operate_class_ff     <= 1'b0;
      op_ext_ff            <= 9'h000;
      dev_sel_ff           <= 6'h00;
      pulse4_en_ff         <= 1'b0;
      pulse2_en_ff         <= 1'b0;
      pulse1_en_ff         <= 1'b0;
    end else if (clk_en) begin
      done_ff <= 1'b0;
      case (state_ff)
        TBID_IDLE: begin
          if (go_w) begin
            state_ff             <= TBID_EXEC;
            cnt_ff               <= len_w;
            busy_ff              <= 1'b1;
            opcode_ff            <= op_w; // RULE1
            mem_ref_ff           <= is_mem; // RULE2
            io_transfer_class_ff <= is_io; // RULE3
            operate_class_ff     <= is_opr; // RULE3
            op_ext_ff            <= (is_io || is_opr) ? ext_w : 9'h000; // RULE4
            dev_sel_ff           <= is_io ? sel_w : 6'h00; // RULE6
            pulse4_en_ff         <= is_io & instr[`TBID_P4_BIT]; // RULE7
            pulse2_en_ff         <= is_io & instr[`TBID_P2_BIT]; // RULE7
            pulse1_en_ff         <= is_io & instr[`TBID_P1_BIT]; // RULE7
          end
        end
        TBID_EXEC: begin
          cnt_ff <= cnt_ff - `TBID_CNT_W'(1);
          if (last_w) begin
            state_ff     <= TBID_DONE;
            busy_ff      <= 1'b0;
            done_ff      <= 1'b1;
            pulse4_en_ff <= 1'b0;
            pulse2_en_ff <= 1'b0;
            pulse1_en_ff <= 1'b0;
          end
        end
        TBID_DONE: state_ff <= TBID_IDLE;
        default:   state_ff <= TBID_IDLE;
      endcase
    end
  end

  // Architectural state updates at the start of execution; operand must be stable with start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      working_register_ff <= 12'h000;
      link_ff             <= 1'b0;
      pc_ff               <= 12'h000;
      mem_we_ff           <= 1'b0;
      mem_addr_ff         <= 12'h000;
      mem_wdata_ff        <= 12'h000;
    end else if (clk_en) begin
      mem_we_ff <= 1'b0;
      if (go_w) begin
        mem_addr_ff <= target_addr; // RULE15
        pc_ff       <= pc_next; // RULE14
        case (tbid_op_t'(op_w))
          TBID_OP_AND: working_register_ff <= working_register_ff & mem_rdata; // RULE8
          TBID_OP_ADD: begin
            working_register_ff <= sum_w[`TBID_MSB:0]; // RULE9
            link_ff             <= link_ff ^ sum_w[`TBID_W]; // RULE9
          end
          TBID_OP_ISZ_: begin
            mem_we_ff    <= 1'b1; // RULE10
            mem_wdata_ff <= inc_w; // RULE10
            if (inc_zero) begin
              pc_ff <= pc_skip; // RULE10 RULE14
            end
          end
          TBID_OP_DEP: begin
            mem_we_ff           <= 1'b1; // RULE11
            mem_wdata_ff        <= working_register_ff; // RULE11
            working_register_ff <= `TBID_ZERO; // RULE11
          end
          TBID_OP_CALL: begin
            mem_we_ff    <= 1'b1; // RULE12
            mem_wdata_ff <= pc_next; // RULE12
            pc_ff        <= call_pc; // RULE12
          end
          TBID_OP_JUMP: pc_ff <= target_addr; // RULE13
          default: mem_addr_ff <= ret_w;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/tbid_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module tbid_mem_model (
  // Design side
  input  wire logic        clock,
  input  wire logic        mem_we_ff,
  input  wire logic [11:0] target_addr,
  input  wire logic [11:0] mem_addr_ff,
  input  wire logic [11:0] mem_wdata_ff,
  // Operand back
  output logic      [11:0] mem_rdata
);
  // Sixteen words suffice; upper address bits wrap
  logic [11:0] ram [16];
  assign mem_rdata = ram[target_addr[3:0]];
  always @(posedge clock) begin
    if (mem_we_ff) begin
      ram[mem_addr_ff[3:0]] <= mem_wdata_ff;
    end
  end
endmodule
`default_nettype wire

// ===== sim/tbid_decode_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tbid_decode_monitor (
  input wire logic        clock, rst, start, busy_ff, done_ff,
  input wire logic [11:0] instr, target_addr, pc_ff,
  input wire logic [2:0]  opcode_ff,
  input wire logic        mem_ref_ff, io_transfer_class_ff, operate_class_ff,
  input wire logic [8:0]  op_ext_ff,
  input wire logic [5:0]  dev_sel_ff,
  input wire logic        pulse4_en_ff, pulse2_en_ff, pulse1_en_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // The done cycle still refuses a start
  wire       tk = start && !busy_ff && !done_ff;
  wire [2:0] op = instr[11:9];
  a_opcode_field: assert property (tk |=> opcode_ff == $past(op)) else $error("opcode");
  a_class_decode: assert property (tk |=> mem_ref_ff == ($past(op) < 3'h6)
    && io_transfer_class_ff == ($past(op) == 3'h6) && operate_class_ff == ($past(op) == 3'h7))
    else $error("class");
  a_ext_field: assert property (
    tk |=> op_ext_ff == ($past(op) > 3'h5 ? $past(instr[8:0]) : 9'h000))
    else $error("ext");
  a_aug_timing: assert property (
    tk && op > 3'h4 |-> ##15 busy_ff && !done_ff ##1 done_ff)
    else $error("short time");
  a_mri_timing: assert property (
    tk && op < 3'h5 |-> ##30 busy_ff ##1 done_ff)
    else $error("long time");
  a_dev_select: assert property (
    tk |=> dev_sel_ff == ($past(op) == 3'h6 ? $past(instr[8:3]) : 6'h00))
    else $error("select");
  a_io_pulses: assert property (tk && op == 3'h6 |=>
    {pulse4_en_ff, pulse2_en_ff, pulse1_en_ff} == $past(instr[2:0])) else $error("pulses");
  a_jump_target: assert property (
    tk && op == 3'h5 |=> pc_ff == $past(target_addr))
    else $error("jump");
endmodule
bind tbid_decode tbid_decode_monitor u_mon (.clock, .rst, .start, .busy_ff, .done_ff, .instr,
  .target_addr, .pc_ff, .opcode_ff, .mem_ref_ff, .io_transfer_class_ff, .operate_class_ff,
  .op_ext_ff, .dev_sel_ff, .pulse4_en_ff, .pulse2_en_ff, .pulse1_en_ff);
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clock = 0, rst = 1, start = 0, busy_ff, done_ff, link_ff, mem_we_ff, mem_ref_ff;
  logic        io_transfer_class_ff, operate_class_ff, pulse4_en_ff, pulse2_en_ff, pulse1_en_ff;
  logic [11:0] instr = 0, target_addr = 0, mem_rdata, working_register_ff, pc_ff;
  logic [11:0] mem_addr_ff, mem_wdata_ff;
  logic [2:0]  opcode_ff;
  logic [8:0]  op_ext_ff;
  logic [5:0]  dev_sel_ff;
  int          bad_count = 0, cmp_count = 0;
  always #50 clock = ~clock;
  tbid_decode dut (.clock, .rst, .clk_en(1'b1), .start, .instr, .target_addr, .mem_rdata,
    .busy_ff, .done_ff, .working_register_ff, .link_ff, .pc_ff, .mem_we_ff, .mem_addr_ff,
    .mem_wdata_ff, .opcode_ff, .mem_ref_ff, .io_transfer_class_ff, .operate_class_ff,
    .op_ext_ff, .dev_sel_ff, .pulse4_en_ff, .pulse2_en_ff, .pulse1_en_ff);
  tbid_mem_model mdl (.clock, .mem_we_ff, .target_addr, .mem_addr_ff, .mem_wdata_ff, .mem_rdata);
  task print_verdict;
    if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic ok);
    cmp_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("Error %0t: mismatch", $time);
    end
  endtask
  // Issue one word, count cycles to done, then check the fetch address
  task run(input logic [11:0] i, a, input int n, input logic [11:0] p);
    int k;
    @(posedge clock);
    start <= 1'b1;
    instr <= i;
    target_addr <= a;
    @(posedge clock);
    start <= 1'b0;
    k = 0;
    while (done_ff !== 1'b1 && k < 40) begin
      @(negedge clock);
      k++;
    end
    if (k == 40) begin
      bad_count++;
      print_verdict;
    end
    chk(k == n);
    chk(pc_ff === p);
  endtask
  task t_add;
    run(12'h200, 12'h001, 31, 12'h001);
    chk(working_register_ff === 12'hFFF && link_ff === 1'b0);
    run(12'h200, 12'h002, 31, 12'h002);
    chk(working_register_ff === 12'h000 && link_ff === 1'b1);
  endtask
  task t_and_dep;
    run(12'h200, 12'h003, 31, 12'h003);
    run(12'h000, 12'h004, 31, 12'h004);
    chk(working_register_ff === 12'h05A && mdl.ram[4] === 12'h0FF);
    run(12'h600, 12'h005, 31, 12'h005);
    chk(working_register_ff === 12'h000 && mdl.ram[5] === 12'h05A);
  endtask
  task t_isz;
    run(12'h400, 12'h006, 31, 12'h007);
    chk(mdl.ram[6] === 12'h000 && working_register_ff === 12'h000);
    run(12'h400, 12'h006, 31, 12'h008);
  endtask
  task t_call_jump;
    run(12'h800, 12'h007, 31, 12'h008);
    chk(mdl.ram[7] === 12'h009);
    run(12'hA00, 12'h0C3, 16, 12'h0C3);
  endtask
  task t_aug;
    run(12'hC5D, 12'h000, 16, 12'h0C4);
    chk(dev_sel_ff === 6'h0B && io_transfer_class_ff === 1'b1);
    chk(op_ext_ff === 9'h05D && opcode_ff === 3'h6 && mem_ref_ff === 1'b0);
    chk({pulse4_en_ff, pulse2_en_ff, pulse1_en_ff} === 3'b000);
    run(12'hE00, 12'h000, 16, 12'h0C5);
    chk(operate_class_ff === 1'b1 && working_register_ff === 12'h000);
  endtask
  initial begin
    mdl.ram[1] = 12'hFFF;
    mdl.ram[2] = 12'h001;
    mdl.ram[3] = 12'hA5A;
    mdl.ram[4] = 12'h0FF;
    mdl.ram[6] = 12'hFFF;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_add;
    t_and_dep;
    t_isz;
    t_call_jump;
    t_aug;
    print_verdict;
  end
endmodule
`default_nettype wire
